// ### pkg/sipa_pkg.sv
/*
 constants, offsets, field positions, reset values and types of the servo
 input/output pin assignment block; assumes one 125 MHz clock domain.
*/
// Behaviour
// - connector A pin 8 carries the function named by its selector, reset 0665
// - connector B pin 7 carries the function named by its selector, reset 0770
// - connector B pin 8 carries the function named by its selector, reset 0883
// - connector B pin 9 carries the function named by its selector, reset 0994
// - each selector holds position, speed and torque choices; active mode's choice applies
// - a pin given to control mode change ignores its own selector
// - absolute detection on: connector B pin 8 becomes transfer mode input
// - absolute detection on: connector B pin 9 becomes position request input
// - output select 0 gives status flags; 1 gives alarm code during an alarm while absolute detection is off
// - alarm code output with absolute detection raises the parameter error alarm
package sipa_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int SEL_W = 16;
   localparam int NIB_W = 4;
   localparam int NUM_FUNC = 16;
   localparam int CODE_W = 3;
   localparam int GRP_W = 4;

   localparam logic [5:0] OFF_SEL_A8 = 6'h00;
   localparam logic [5:0] OFF_SEL_B7 = 6'h04;
   localparam logic [5:0] OFF_SEL_B8 = 6'h08;
   localparam logic [5:0] OFF_SEL_B9 = 6'h0C;
   localparam logic [5:0] OFF_OSEL = 6'h10;
   localparam logic [5:0] OFF_CFG = 6'h14;
   localparam logic [5:0] OFF_IRQ_STAT = 6'h18;
   localparam logic [5:0] OFF_IRQ_MASK = 6'h1C;
   localparam logic [5:0] OFF_PIN_STAT = 6'h20;

   localparam logic [15:0] RST_SEL_A8 = 16'h0665;
   localparam logic [15:0] RST_SEL_B7 = 16'h0770;
   localparam logic [15:0] RST_SEL_B8 = 16'h0883;
   localparam logic [15:0] RST_SEL_B9 = 16'h0994;
   localparam logic [15:0] RST_OSEL = 16'h0000;
   localparam logic [15:0] RST_CFG = 16'h0000;

   localparam int NIB_P_LSB = 0;
   localparam int NIB_S_LSB = 4;
   localparam int NIB_T_LSB = 8;
   localparam logic [3:0] OSEL_ALARM_CODE = 4'h1;

   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_ABS_BIT = 2;
   localparam int CFG_LOP_LSB = 4;
   localparam logic [1:0] MODE_CFG_SPD = 2'h1;
   localparam logic [1:0] MODE_CFG_TRQ = 2'h2;

   localparam logic [2:0] LOP_A8 = 3'h1;
   localparam logic [2:0] LOP_B7 = 3'h2;
   localparam logic [2:0] LOP_B8 = 3'h3;
   localparam logic [2:0] LOP_B9 = 3'h4;

   localparam int IRQ_W = 2;
   localparam int IRQ_PARAM = 0;
   localparam int IRQ_ALARM = 1;

   // per-group pattern: memory, clock, parameter, comm timeout, overload,
   // overheat, overspeed, main circuit, encoder; unused groups give 0
   localparam logic [2:0] ALM_CODE [0:15] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h5,
      3'h6, 3'h7, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};

   typedef enum logic [2:0] {
      SIPA_MODE_POS = 3'b001,
      SIPA_MODE_SPD = 3'b010,
      SIPA_MODE_TRQ = 3'b100
   } sipa_mode_t;
endpackage

// ### design/sipa_top.sv
/*
 servo input/output pin assignment: routes four input pins onto assignable
 functions per control mode and drives three status/alarm code outputs;
 register access over an Avalon-MM slave with waitrequest.
 assumes all inputs synchronous to mclk_i and a bus master that holds its
 request until waitrequest is seen low.
*/
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module sipa_top #(
   parameter int SEL_WIDTH = 16
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic pin_a8_i,
   input wire logic pin_b7_i,
   input wire logic pin_b8_i,
   input wire logic pin_b9_i,
   input wire logic zero_speed_flag_i,
   input wire logic in_position_flag_i,
   input wire logic speed_reached_flag_i,
   input wire logic ready_flag_i,
   input wire logic alarm_active_i,
   input wire logic [3:0] alarm_group_i,
   output logic [15:0] func_active_o,
   output logic control_mode_change_o,
   output logic abs_transfer_mode_o,
   output logic abs_request_o,
   output logic out_b19_o,
   output logic out_a18_o,
   output logic out_a19_o,
   output logic parameter_error_alarm_o,
   output logic irq_o
);
   initial begin
      if (SEL_WIDTH < 3 * sipa_pkg::NIB_W || SEL_WIDTH > sipa_pkg::SEL_W) begin
         $error("SEL_WIDTH must hold three mode digits and fit a 16-bit register");
      end
   end

   function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
      be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   function automatic logic [3:0] pick_code(input logic [15:0] sel,
                                            input sipa_pkg::sipa_mode_t md);
      pick_code = sel[sipa_pkg::NIB_P_LSB +: sipa_pkg::NIB_W];
      unique case (md)
         sipa_pkg::SIPA_MODE_POS: pick_code = sel[sipa_pkg::NIB_P_LSB +: sipa_pkg::NIB_W];
         sipa_pkg::SIPA_MODE_SPD: pick_code = sel[sipa_pkg::NIB_S_LSB +: sipa_pkg::NIB_W];
         sipa_pkg::SIPA_MODE_TRQ: pick_code = sel[sipa_pkg::NIB_T_LSB +: sipa_pkg::NIB_W];
      endcase
   endfunction

   function automatic logic [15:0] onehot(input logic [3:0] code, input logic act);
      onehot = act ? (16'h0001 << code) : 16'h0000;
   endfunction

   logic [15:0] sel_a8_ff, sel_b7_ff, sel_b8_ff, sel_b9_ff, osel_ff, cfg_ff;
   logic [1:0] irq_stat_ff, irq_mask_ff;
   logic [2:0] alm_code_ff;
   logic alarm_seen_ff;
   logic [31:0] nxt_rdata;

   // bus decode
   wire req = avs_read_i | avs_write_i;
   wire take = ce_i & req & avs_waitrequest_o;
   wire commit = ce_i & avs_write_i & ~avs_waitrequest_o;
   wire wr_a8 = commit & (avs_address_i == sipa_pkg::OFF_SEL_A8);
   wire wr_b7 = commit & (avs_address_i == sipa_pkg::OFF_SEL_B7);
   wire wr_b8 = commit & (avs_address_i == sipa_pkg::OFF_SEL_B8);
   wire wr_b9 = commit & (avs_address_i == sipa_pkg::OFF_SEL_B9);
   wire wr_osel = commit & (avs_address_i == sipa_pkg::OFF_OSEL);
   wire wr_cfg = commit & (avs_address_i == sipa_pkg::OFF_CFG);
   wire wr_stat = commit & (avs_address_i == sipa_pkg::OFF_IRQ_STAT);
   wire wr_mask = commit & (avs_address_i == sipa_pkg::OFF_IRQ_MASK);

   // configuration decode
   wire [1:0] mode_fld = cfg_ff[sipa_pkg::CFG_MODE_LSB +: 2];
   wire abs_en = cfg_ff[sipa_pkg::CFG_ABS_BIT];
   wire [2:0] lop_sel = cfg_ff[sipa_pkg::CFG_LOP_LSB +: 3];
   // undefined mode code falls back to position mode
   sipa_pkg::sipa_mode_t mode_q;
   assign mode_q = (mode_fld == sipa_pkg::MODE_CFG_SPD) ? sipa_pkg::SIPA_MODE_SPD :
                   (mode_fld == sipa_pkg::MODE_CFG_TRQ) ? sipa_pkg::SIPA_MODE_TRQ :
                   sipa_pkg::SIPA_MODE_POS;

   // absolute detection wins over a mode change assignment on pins b8/b9
   wire a8_en = (lop_sel != sipa_pkg::LOP_A8);
   wire b7_en = (lop_sel != sipa_pkg::LOP_B7);
   wire b8_en = (lop_sel != sipa_pkg::LOP_B8) & ~abs_en;
   wire b9_en = (lop_sel != sipa_pkg::LOP_B9) & ~abs_en;

   wire [3:0] code_a8 = pick_code(sel_a8_ff, mode_q);
   wire [3:0] code_b7 = pick_code(sel_b7_ff, mode_q);
   wire [3:0] code_b8 = pick_code(sel_b8_ff, mode_q);
   wire [3:0] code_b9 = pick_code(sel_b9_ff, mode_q);

   wire [15:0] nxt_func = onehot(code_a8, a8_en & pin_a8_i)
                        | onehot(code_b7, b7_en & pin_b7_i)
                        | onehot(code_b8, b8_en & pin_b8_i)
                        | onehot(code_b9, b9_en & pin_b9_i);

   wire nxt_lop = ((lop_sel == sipa_pkg::LOP_A8) & pin_a8_i)
                | ((lop_sel == sipa_pkg::LOP_B7) & pin_b7_i)
                | ((lop_sel == sipa_pkg::LOP_B8) & ~abs_en & pin_b8_i)
                | ((lop_sel == sipa_pkg::LOP_B9) & ~abs_en & pin_b9_i);

   // output selection
   wire osel_code = (osel_ff[3:0] == sipa_pkg::OSEL_ALARM_CODE);
   wire conflict = osel_code & abs_en;
   wire alm_mode = osel_code & ~abs_en;
   wire alarm_rise = alarm_active_i & ~alarm_seen_ff;
   // code frozen at alarm onset so a group change mid-alarm cannot glitch it
   wire [2:0] cur_code = alarm_rise ? sipa_pkg::ALM_CODE[alarm_group_i] : alm_code_ff;
   wire show_code = alm_mode & alarm_active_i;
   wire nxt_mid = (mode_q == sipa_pkg::SIPA_MODE_POS) ? in_position_flag_i
                                                      : speed_reached_flag_i;
   wire [2:0] nxt_out = show_code ? cur_code
                                  : {zero_speed_flag_i, nxt_mid, ready_flag_i};

   // interrupts: set wins over a clear in the same cycle
   wire [1:0] ev = {alarm_rise, conflict & ~parameter_error_alarm_o};
   wire [1:0] clr = wr_stat & avs_byteenable_i[0] ? avs_writedata_i[1:0] : 2'h0;
   wire [1:0] nxt_stat = (irq_stat_ff & ~clr) | ev;
   // new mask used at once so irq never lags a mask write by a cycle
   wire [1:0] nxt_mask = (wr_mask & avs_byteenable_i[0]) ? avs_writedata_i[1:0] : irq_mask_ff;

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (avs_address_i)
         sipa_pkg::OFF_SEL_A8: nxt_rdata[15:0] = sel_a8_ff;
         sipa_pkg::OFF_SEL_B7: nxt_rdata[15:0] = sel_b7_ff;
         sipa_pkg::OFF_SEL_B8: nxt_rdata[15:0] = sel_b8_ff;
         sipa_pkg::OFF_SEL_B9: nxt_rdata[15:0] = sel_b9_ff;
         sipa_pkg::OFF_OSEL: nxt_rdata[15:0] = osel_ff;
         sipa_pkg::OFF_CFG: nxt_rdata[15:0] = cfg_ff;
         sipa_pkg::OFF_IRQ_STAT: nxt_rdata[1:0] = irq_stat_ff;
         sipa_pkg::OFF_IRQ_MASK: nxt_rdata[1:0] = irq_mask_ff;
         sipa_pkg::OFF_PIN_STAT: nxt_rdata[11:0] = {parameter_error_alarm_o, abs_request_o,
            abs_transfer_mode_o, control_mode_change_o, out_b19_o, out_a18_o, out_a19_o,
            1'b0, pin_a8_i, pin_b7_i, pin_b8_i, pin_b9_i};
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   // waitrequest: one wait cycle per access, unmapped reads answer zero
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h0000_0000;
      end else if (ce_i) begin
         avs_waitrequest_o <= ~take;
         if (take & avs_read_i) begin
            avs_readdata_o <= nxt_rdata;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sel_a8_ff <= sipa_pkg::RST_SEL_A8;
         sel_b7_ff <= sipa_pkg::RST_SEL_B7;
         sel_b8_ff <= sipa_pkg::RST_SEL_B8;
         sel_b9_ff <= sipa_pkg::RST_SEL_B9;
         osel_ff <= sipa_pkg::RST_OSEL;
         cfg_ff <= sipa_pkg::RST_CFG;
         irq_mask_ff <= 2'h0;
      end else begin
         if (wr_a8) begin
            sel_a8_ff <= be_merge(sel_a8_ff, avs_writedata_i, avs_byteenable_i);
         end
         if (wr_b7) begin
            sel_b7_ff <= be_merge(sel_b7_ff, avs_writedata_i, avs_byteenable_i);
         end
         if (wr_b8) begin
            sel_b8_ff <= be_merge(sel_b8_ff, avs_writedata_i, avs_byteenable_i);
         end
         if (wr_b9) begin
            sel_b9_ff <= be_merge(sel_b9_ff, avs_writedata_i, avs_byteenable_i);
         end
         if (wr_osel) begin
            osel_ff <= be_merge(osel_ff, avs_writedata_i, avs_byteenable_i);
         end
         if (wr_cfg) begin
            cfg_ff <= be_merge(cfg_ff, avs_writedata_i, avs_byteenable_i);
         end
         if (wr_mask & avs_byteenable_i[0]) begin
            irq_mask_ff <= avs_writedata_i[1:0];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         func_active_o <= 16'h0000;
         control_mode_change_o <= 1'b0;
         abs_transfer_mode_o <= 1'b0;
         abs_request_o <= 1'b0;
      end else if (ce_i) begin
         func_active_o <= nxt_func;
         control_mode_change_o <= nxt_lop;
         abs_transfer_mode_o <= abs_en & pin_b8_i;
         abs_request_o <= abs_en & pin_b9_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         {out_b19_o, out_a18_o, out_a19_o} <= 3'h0;
         alm_code_ff <= 3'h0;
         alarm_seen_ff <= 1'b0;
         parameter_error_alarm_o <= 1'b0;
         irq_stat_ff <= 2'h0;
         irq_o <= 1'b0;
      end else if (ce_i) begin
         {out_b19_o, out_a18_o, out_a19_o} <= nxt_out;
         alm_code_ff <= cur_code;
         alarm_seen_ff <= alarm_active_i;
         parameter_error_alarm_o <= conflict;
         irq_stat_ff <= nxt_stat;
         irq_o <= |(nxt_stat & nxt_mask);
      end
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_alarm_held;
      ce_i && alm_mode && alarm_active_i ##1 ce_i && alm_mode && alarm_active_i;
   endsequence

   sequence s_alarm_onset;
      ce_i && alm_mode && alarm_active_i && !alarm_seen_ff;
   endsequence

   sequence s_bus_take;
      ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence

   chk_a8_route: assert property (
      ce_i && a8_en && pin_a8_i |=> func_active_o[$past(code_a8)])
      else $error("pin a8 function not raised");
   chk_b7_route: assert property (
      ce_i && b7_en && pin_b7_i |=> func_active_o[$past(code_b7)])
      else $error("pin b7 function not raised");
   chk_b8_route: assert property (
      ce_i && b8_en && pin_b8_i |=> func_active_o[$past(code_b8)])
      else $error("pin b8 function not raised");
   chk_b9_route: assert property (
      ce_i && b9_en && pin_b9_i |=> func_active_o[$past(code_b9)])
      else $error("pin b9 function not raised");
   chk_speed_digit: assert property (
      ce_i && mode_q == sipa_pkg::SIPA_MODE_SPD && a8_en && pin_a8_i
      |=> func_active_o[$past(sel_a8_ff[7:4])])
      else $error("speed mode digit not applied");
   chk_lop_pin: assert property (
      ce_i && lop_sel == sipa_pkg::LOP_A8 && !pin_b7_i && !pin_b8_i && !pin_b9_i
      |=> control_mode_change_o == $past(pin_a8_i) && func_active_o == 16'h0000)
      else $error("mode change pin mishandled");
   chk_abs_mode: assert property (
      ce_i && abs_en |=> abs_transfer_mode_o == $past(pin_b8_i))
      else $error("transfer mode input not taken from b8");
   chk_abs_request: assert property (
      ce_i && abs_en |=> abs_request_o == $past(pin_b9_i))
      else $error("request input not taken from b9");
   chk_status_out: assert property (
      ce_i && !show_code |=> out_b19_o == $past(zero_speed_flag_i)
      && out_a19_o == $past(ready_flag_i))
      else $error("status outputs wrong");
   chk_param_err: assert property (
      ce_i && osel_code && abs_en |=> parameter_error_alarm_o
      && (irq_stat_ff[sipa_pkg::IRQ_PARAM] || $past(parameter_error_alarm_o)))
      else $error("parameter error not raised");
   chk_code_value: assert property (
      s_alarm_onset |=> {out_b19_o, out_a18_o, out_a19_o}
      == sipa_pkg::ALM_CODE[$past(alarm_group_i)])
      else $error("alarm code pattern wrong");
   chk_code_stable: assert property (
      s_alarm_held |=> $stable({out_b19_o, out_a18_o, out_a19_o}))
      else $error("alarm code changed during alarm");
   chk_bus_answer: assert property (
      s_bus_take |=> !avs_waitrequest_o)
      else $error("no bus answer after one wait cycle");
   chk_wait_pulse: assert property (
      ce_i && !avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   chk_read_a8: assert property (
      s_bus_take ##0 (avs_read_i && avs_address_i == sipa_pkg::OFF_SEL_A8)
      |=> avs_readdata_o[15:0] == $past(sel_a8_ff))
      else $error("selector a8 read back wrong");

   // status bits are sticky: only a one written to them clears them
   chk_stat_sticky: assert property (
      ce_i && !wr_stat |=> (irq_stat_ff & $past(irq_stat_ff)) == $past(irq_stat_ff))
      else $error("status bit lost without a clear");
   chk_alarm_flag: assert property (
      ce_i && alarm_active_i && !alarm_seen_ff |=> irq_stat_ff[sipa_pkg::IRQ_ALARM])
      else $error("alarm onset not recorded");
   chk_mask_hold: assert property (
      ce_i && !wr_mask |=> $stable(irq_mask_ff))
      else $error("interrupt mask changed without a write");
   chk_irq_level: assert property (
      irq_o == |(irq_stat_ff & irq_mask_ff))
      else $error("interrupt level disagrees with status and mask");

   chk_pos_digit: assert property (
      ce_i && mode_q == sipa_pkg::SIPA_MODE_POS && a8_en && pin_a8_i
      |=> func_active_o[$past(sel_a8_ff[sipa_pkg::NIB_P_LSB +: sipa_pkg::NIB_W])])
      else $error("position mode digit not applied");
   chk_torque_digit: assert property (
      ce_i && mode_q == sipa_pkg::SIPA_MODE_TRQ && a8_en && pin_a8_i
      |=> func_active_o[$past(sel_a8_ff[sipa_pkg::NIB_T_LSB +: sipa_pkg::NIB_W])])
      else $error("torque mode digit not applied");
   chk_lop_idle: assert property (
      ce_i && lop_sel != sipa_pkg::LOP_A8 && lop_sel != sipa_pkg::LOP_B7
      && lop_sel != sipa_pkg::LOP_B8 && lop_sel != sipa_pkg::LOP_B9
      |=> !control_mode_change_o)
      else $error("mode change raised with no pin assigned");
   chk_abs_idle: assert property (
      ce_i && !abs_en |=> !abs_transfer_mode_o && !abs_request_o)
      else $error("absolute inputs active while detection is off");
   chk_abs_block: assert property (
      ce_i && abs_en && !pin_a8_i && !pin_b7_i |=> func_active_o == 16'h0000)
      else $error("pin b8 or b9 still routed under absolute detection");
   chk_mid_pos: assert property (
      ce_i && !show_code && mode_q == sipa_pkg::SIPA_MODE_POS
      |=> out_a18_o == $past(in_position_flag_i))
      else $error("in-position flag not shown");
   chk_mid_speed: assert property (
      ce_i && !show_code && mode_q != sipa_pkg::SIPA_MODE_POS
      |=> out_a18_o == $past(speed_reached_flag_i))
      else $error("speed-reached flag not shown");
   chk_perr_clear: assert property (
      ce_i && !(osel_code && abs_en) |=> !parameter_error_alarm_o)
      else $error("parameter error without a conflict");
endmodule

// ### dv/sipa_ctrl_model.sv
/*
 external motion controller model: drives the four input pins and decodes
 the three alarm code outputs into an alarm group.
 assumes one clock shared with the block under test.
*/
`timescale 1ns/1ps
module sipa_ctrl_model (
   input wire logic mclk_i,
   input wire logic [3:0] drive_i,
   input wire logic out_b19_i,
   input wire logic out_a18_i,
   input wire logic out_a19_i,
   output logic pin_a8_o,
   output logic pin_b7_o,
   output logic pin_b8_o,
   output logic pin_b9_o,
   output logic [3:0] grp_o
);
   logic [2:0] code;
   // push-pull drivers, so the pins never float
   assign {pin_a8_o, pin_b7_o, pin_b8_o, pin_b9_o} = drive_i;
   assign code = {out_b19_i, out_a18_i, out_a19_i};
   // groups sharing one code cannot be told apart: lowest index wins
   always_ff @(posedge mclk_i) begin
      grp_o <= 4'hF;
      for (int g = 8; g >= 0; g--) begin
         if (sipa_pkg::ALM_CODE[g] == code) begin
            grp_o <= 4'(g);
         end
      end
   end
endmodule

// ### dv/sipa_top_tb_top.sv
/*
 self-checking bench of the pin assignment block: bus tasks, routing,
 override, alarm code and interrupt tests.
 assumes the controller model beside it and one 125 MHz clock.
*/
`timescale 1ns/1ps
module sipa_top_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [5:0] adr = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic wait_req;
   logic [3:0] drive = 4'h0;
   logic zs = 1'b0, ip = 1'b0, sr = 1'b0, rdy = 1'b0, alm = 1'b0;
   logic [3:0] grp = 4'h0, grp_seen;
   logic a8, b7, b8, b9, cmc, abs_transfer_mode, abs_request, ob19, oa18, oa19, perr, irq;
   logic [15:0] fa;
   logic [31:0] got;
   int n_fail = 0;
   int samples_checked = 0;
   logic [15:0] rst_sel [4] = '{16'h0665, 16'h0770, 16'h0883, 16'h0994};

   initial forever #4 clk = ~clk;

   sipa_ctrl_model i_ctrl (.mclk_i(clk), .drive_i(drive), .out_b19_i(ob19),
      .out_a18_i(oa18), .out_a19_i(oa19), .pin_a8_o(a8), .pin_b7_o(b7),
      .pin_b8_o(b8), .pin_b9_o(b9), .grp_o(grp_seen));

   sipa_top i_dut (.mclk_i(clk), .sys_rst_i(rst), .ce_i(ce), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_req),
      .pin_a8_i(a8), .pin_b7_i(b7), .pin_b8_i(b8), .pin_b9_i(b9),
      .zero_speed_flag_i(zs), .in_position_flag_i(ip), .speed_reached_flag_i(sr),
      .ready_flag_i(rdy), .alarm_active_i(alm), .alarm_group_i(grp),
      .func_active_o(fa), .control_mode_change_o(cmc), .abs_transfer_mode_o(abs_transfer_mode),
      .abs_request_o(abs_request), .out_b19_o(ob19), .out_a18_o(oa18), .out_a19_o(oa19),
      .parameter_error_alarm_o(perr), .irq_o(irq));

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         n_fail++;
      end
   endtask

   // one access: hold everything until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
      adr <= a;
      wdat <= {16'h0000, d};
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge clk);
      end while (wait_req !== 1'b0);
      got = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask

   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      tick(20000);
      n_fail++;
      tally_and_finish;
   end

   initial begin
      tick(20);
      rst <= 1'b0;
      tick(2);
      for (int p = 0; p < 4; p++) begin
         bus(1'b0, 6'(4 * p), 16'h0);
         chk(got, {16'h0, rst_sel[p]});
      end
      bus(1'b1, 6'h24, 16'hFFFF);
      bus(1'b0, 6'h24, 16'h0);
      chk(got, 32'h0);
      $display("test reset_values done");
      for (int p = 0; p < 4; p++) begin
         for (int m = 0; m < 3; m++) begin
            bus(1'b1, sipa_pkg::OFF_CFG, 16'(m));
            drive <= 4'b1000 >> p;
            tick(3);
            chk(fa, 16'h1 << rst_sel[p][4 * m +: 4]);
            drive <= 4'h0;
         end
      end
      bus(1'b1, sipa_pkg::OFF_SEL_A8, 16'h0ABC);
      bus(1'b1, sipa_pkg::OFF_CFG, 16'h0000);
      drive <= 4'b1000;
      tick(3);
      chk(fa, 16'h1000);
      ce <= 1'b0;
      drive <= 4'b0100;
      tick(3);
      chk(fa, 16'h1000);
      ce <= 1'b1;
      tick(3);
      chk(fa, 16'h0001);
      drive <= 4'b1000;
      $display("test routing done");
      bus(1'b1, sipa_pkg::OFF_CFG, 16'h0010);
      tick(3);
      chk({cmc, fa}, 17'h10000);
      drive <= 4'b0011;
      bus(1'b1, sipa_pkg::OFF_CFG, 16'h0004);
      tick(3);
      chk({abs_transfer_mode, abs_request, fa}, 18'h30000);
      drive <= 4'b0010;
      tick(3);
      chk({abs_transfer_mode, abs_request, fa}, 18'h20000);
      drive <= 4'h0;
      $display("test overrides done");
      bus(1'b1, sipa_pkg::OFF_CFG, 16'h0000);
      zs <= 1'b1;
      sr <= 1'b1;
      rdy <= 1'b1;
      tick(3);
      chk({ob19, oa18, oa19}, 3'b101);
      bus(1'b1, sipa_pkg::OFF_CFG, 16'h0001);
      tick(3);
      chk({ob19, oa18, oa19}, 3'b111);
      bus(1'b1, sipa_pkg::OFF_OSEL, 16'h0001);
      zs <= 1'b0;
      tick(3);
      chk({ob19, oa18, oa19}, 3'b011);
      for (int g = 0; g < 9; g++) begin
         grp <= 4'(g);
         alm <= 1'b1;
         tick(4);
         chk({ob19, oa18, oa19}, sipa_pkg::ALM_CODE[g]);
         chk(sipa_pkg::ALM_CODE[grp_seen], sipa_pkg::ALM_CODE[g]);
         grp <= 4'(g + 3);
         tick(3);
         chk({ob19, oa18, oa19}, sipa_pkg::ALM_CODE[g]);
         alm <= 1'b0;
         tick(2);
      end
      bus(1'b0, sipa_pkg::OFF_IRQ_STAT, 16'h0);
      chk(got, 32'h2);
      bus(1'b1, sipa_pkg::OFF_IRQ_STAT, 16'h0003);
      $display("test alarm_code done");
      bus(1'b1, sipa_pkg::OFF_CFG, 16'h0004);
      tick(3);
      chk({perr, irq}, 2'b10);
      bus(1'b0, sipa_pkg::OFF_IRQ_STAT, 16'h0);
      chk(got, 32'h1);
      bus(1'b1, sipa_pkg::OFF_IRQ_MASK, 16'h0001);
      tick(2);
      chk(irq, 1'b1);
      bus(1'b1, sipa_pkg::OFF_IRQ_STAT, 16'h0001);
      tick(2);
      chk({perr, irq}, 2'b10);
      bus(1'b1, sipa_pkg::OFF_OSEL, 16'h0000);
      tick(3);
      chk(perr, 1'b0);
      $display("test param_error done");
      tally_and_finish;
   end
endmodule
